//--- logic/pdd_absence_timer.sv
// absence qualification counter
// assumes run_i is held high for every cycle the panel is missing
`timescale 1ns/100ps
module pdd_absence_timer #(
  parameter int unsigned LIMIT = pdd_pkg::LOSS_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // control
  input wire logic run_i,
  // status
  output logic expired_o,
  output logic [$clog2(LIMIT+1)-1:0] count_o
);

  localparam int unsigned CNT_W = $clog2(LIMIT + 1);
  localparam logic [CNT_W-1:0] LIMIT_C = CNT_W'(LIMIT);

  // refused at elaboration: a zero limit would trip on the first missing cycle
  if (LIMIT < 1)
  begin : g_bad_limit
    $error("absence limit must be at least one cycle");
  end

  logic [CNT_W-1:0] count_q;

  // saturates at the limit so a long absence cannot wrap and re-qualify
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      count_q <= '0;
    end
    else if (!run_i)
    begin
      count_q <= '0;
    end
    else if (count_q != LIMIT_C)
    begin
      count_q <= count_q + CNT_W'(1);
    end
  end

  assign expired_o = run_i && (count_q == LIMIT_C);
  assign count_o = count_q;

endmodule : pdd_absence_timer

//--- logic/pdd_panel_disconnect_detector.sv
// operator panel disconnection detector and reset gate of the drive controller
// assumes panel presence, selection and reset inputs are synchronous to clk_sys_i
`timescale 1ns/100ps
module pdd_panel_disconnect_detector #(
  parameter int unsigned LOSS_CYCLES = pdd_pkg::LOSS_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // operator panel
  input wire logic operator_panel_present_i,
  input wire logic alt_panel_model_i,
  // drive settings and status
  input wire logic [pdd_pkg::SEL_W-1:0] reset_and_panel_loss_select_i,
  input wire logic protective_trip_i,
  input wire logic ext_reset_i,
  // results
  output logic drive_reset_o,
  output pdd_pkg::pdd_alarm_s alarm_o
);

  localparam int unsigned CNT_W = $clog2(LOSS_CYCLES + 1);

  // refused at elaboration, not at run time
  if (LOSS_CYCLES < 1)
  begin : g_bad_loss_cycles
    $error("loss qualification must be at least one cycle");
  end

  // ****************************************************************
  // selection decode
  // ****************************************************************
  function automatic logic sel_detect(input logic [pdd_pkg::SEL_W-1:0] sel);
    sel_detect = sel[pdd_pkg::SEL_DETECT_BIT];
  endfunction : sel_detect

  function automatic logic sel_reset_gated(input logic [pdd_pkg::SEL_W-1:0] sel);
    sel_reset_gated = sel[pdd_pkg::SEL_RESET_GATED_BIT];
  endfunction : sel_reset_gated

  pdd_pkg::pdd_state_e state_q;
  pdd_pkg::pdd_alarm_s alarm_q;
  logic drive_reset_q;
  logic detect_en;
  logic reset_ok;
  logic timer_expired;
  logic [CNT_W-1:0] timer_count;

  assign detect_en = sel_detect(reset_and_panel_loss_select_i);

  // the panel loss alarm is itself a protection trip, so a gated reset can clear it
  assign reset_ok = ext_reset_i && (!sel_reset_gated(reset_and_panel_loss_select_i) ||
    protective_trip_i || alarm_q.alarm_stop);

  // ****************************************************************
  // absence timer
  // ****************************************************************
  pdd_absence_timer #(
    .LIMIT(LOSS_CYCLES)
  ) u_timer (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .run_i(state_q == pdd_pkg::PDD_ABSENT && !operator_panel_present_i),
    .expired_o(timer_expired),
    .count_o(timer_count)
  );

  // ****************************************************************
  // detection state
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= pdd_pkg::PDD_UNARMED;
    end
    else
    begin
      unique case (state_q)
        pdd_pkg::PDD_UNARMED:
        begin
          if (operator_panel_present_i)
          begin
            state_q <= pdd_pkg::PDD_ARMED;
          end
        end
        pdd_pkg::PDD_ARMED:
        begin
          if (detect_en && !operator_panel_present_i)
          begin
            state_q <= pdd_pkg::PDD_ABSENT;
          end
        end
        pdd_pkg::PDD_ABSENT:
        begin
          if (operator_panel_present_i || !detect_en)
          begin
            state_q <= pdd_pkg::PDD_ARMED;
          end
          else if (timer_expired)
          begin
            state_q <= pdd_pkg::PDD_TRIPPED;
          end
        end
        pdd_pkg::PDD_TRIPPED:
        begin
          // re-arming needs the panel to be seen again after the reset
          if (reset_ok)
          begin
            state_q <= pdd_pkg::PDD_UNARMED;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // alarm and drive reset outputs
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      alarm_q <= '{alarm_stop: 1'b0, panel_msg_disconnected: 1'b0, led_fault_code: pdd_pkg::CODE_NONE};
    end
    else if (state_q == pdd_pkg::PDD_ABSENT && !operator_panel_present_i && detect_en && timer_expired)
    begin
      alarm_q.alarm_stop <= 1'b1;
      alarm_q.panel_msg_disconnected <= 1'b1;
      alarm_q.led_fault_code <= alt_panel_model_i ? pdd_pkg::ALT_PANEL_LOSS_FAULT_CODE :
        pdd_pkg::PANEL_LOSS_FAULT_CODE;
    end
    else if (alarm_q.alarm_stop && reset_ok)
    begin
      alarm_q <= '{alarm_stop: 1'b0, panel_msg_disconnected: 1'b0, led_fault_code: pdd_pkg::CODE_NONE};
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      drive_reset_q <= 1'b0;
    end
    else
    begin
      drive_reset_q <= reset_ok;
    end
  end

  assign drive_reset_o = drive_reset_q;
  assign alarm_o = alarm_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  AST_NO_DETECT_TRIP: assert property (
    $rose(alarm_q.alarm_stop) |-> $past(detect_en))
    else $error("alarm raised with detection disabled");

  AST_RESET_ALWAYS: assert property (
    (ext_reset_i && !reset_and_panel_loss_select_i[pdd_pkg::SEL_RESET_GATED_BIT]) |=> drive_reset_o)
    else $error("ungated reset not accepted");

  AST_RESET_GATED: assert property (
    (reset_and_panel_loss_select_i[pdd_pkg::SEL_RESET_GATED_BIT] && !protective_trip_i && !alarm_q.alarm_stop)
    |=> !drive_reset_o)
    else $error("gated reset accepted without a trip");

  AST_TRIP_ON_EXPIRY: assert property (
    (state_q == pdd_pkg::PDD_ABSENT && detect_en && !operator_panel_present_i && timer_expired)
    |=> alarm_q.alarm_stop && state_q == pdd_pkg::PDD_TRIPPED)
    else $error("expired absence did not trip");

  AST_QUALIFY_TIME: assert property (
    $rose(alarm_q.alarm_stop) |-> $past(timer_count) == CNT_W'(LOSS_CYCLES))
    else $error("alarm raised before full absence time");

  AST_UNARMED_NO_TRIP: assert property (
    (state_q == pdd_pkg::PDD_UNARMED) |=> !$rose(alarm_q.alarm_stop) ##1 !$rose(alarm_q.alarm_stop))
    else $error("alarm raised without a seen panel");

  AST_MAIN_CODE: assert property (
    ($rose(alarm_q.alarm_stop) && !$past(alt_panel_model_i)) |->
    alarm_q.led_fault_code == pdd_pkg::PANEL_LOSS_FAULT_CODE && alarm_q.panel_msg_disconnected)
    else $error("wrong panel loss display");

  AST_ALT_CODE: assert property (
    ($rose(alarm_q.alarm_stop) && $past(alt_panel_model_i)) |->
    alarm_q.led_fault_code == pdd_pkg::ALT_PANEL_LOSS_FAULT_CODE)
    else $error("wrong alternate panel loss code");

  AST_ALARM_HOLDS: assert property (
    (alarm_q.alarm_stop && !ext_reset_i) |=> alarm_q.alarm_stop)
    else $error("alarm dropped without reset");

  AST_TIMER_CLEARS: assert property (
    (state_q == pdd_pkg::PDD_ABSENT && operator_panel_present_i) |=> timer_count == '0)
    else $error("absence timer not cleared on presence");

  COV_TRIP_MAIN: cover property ($rose(alarm_q.alarm_stop) && !alarm_q.led_fault_code[1]);
  COV_TRIP_ALT: cover property ($rose(alarm_q.alarm_stop) && alarm_q.led_fault_code[1]);
  COV_SHORT_ABSENCE: cover property (state_q == pdd_pkg::PDD_ABSENT ##1 state_q == pdd_pkg::PDD_ARMED);
  COV_TRIP_CLEARED: cover property ($fell(alarm_q.alarm_stop));

endmodule : pdd_panel_disconnect_detector

//--- logic/pdd_pkg.sv
// shared constants and types of the panel disconnect detector
// assumes a single 100 MHz system clock and an active-low asynchronous reset
package pdd_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned LOSS_TIME_MS = 1000;
  // least absence time, rounded down to whole cycles, never less than one
  localparam int unsigned LOSS_CYCLES = (LOSS_TIME_MS * (CLK_FREQ_HZ / 1000) + 0) < 1 ? 1 :
    LOSS_TIME_MS * (CLK_FREQ_HZ / 1000);

  // ****************************************************************
  // selection field of reset_and_panel_loss_select
  // ****************************************************************
  localparam int unsigned SEL_W = 2;
  localparam int unsigned SEL_RESET_GATED_BIT = 0;
  localparam int unsigned SEL_DETECT_BIT = 1;
  localparam logic [SEL_W-1:0] SEL_RESET_VAL = 2'h0;

  // ****************************************************************
  // fault codes (values arbitrary)
  // ****************************************************************
  localparam int unsigned CODE_W = 8;
  localparam logic [CODE_W-1:0] CODE_NONE = 8'h00;
  localparam logic [CODE_W-1:0] PANEL_LOSS_FAULT_CODE = 8'hA1;
  localparam logic [CODE_W-1:0] ALT_PANEL_LOSS_FAULT_CODE = 8'hA2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    PDD_UNARMED = 2'h0,
    PDD_ARMED = 2'h1,
    PDD_ABSENT = 2'h3,
    PDD_TRIPPED = 2'h2
  } pdd_state_e;

  typedef struct packed {
    logic alarm_stop;
    logic panel_msg_disconnected;
    logic [CODE_W-1:0] led_fault_code;
  } pdd_alarm_s;

endpackage : pdd_pkg

//--- verif/pdd_panel_disconnect_detector_test.sv
// self-checking bench of the panel disconnect detector
// assumes a shortened loss time; inputs change at the falling edge
`timescale 1ns/100ps
module pdd_panel_disconnect_detector_test;
  localparam int unsigned L = 5;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic present;
  logic alt_model;
  logic [1:0] sel = 2'h0;
  logic trip = 1'b0;
  logic ext_rst = 1'b0;
  logic drive_reset;
  pdd_pkg::pdd_alarm_s alarm;
  int num_errors = 0;
  int check_count = 0;

  always #5 clk_sys = ~clk_sys;

  pdd_panel_model pdd_panel_model_i (.clk_sys_i(clk_sys), .present_o(present), .alt_model_o(alt_model));

  pdd_panel_disconnect_detector #(.LOSS_CYCLES(L)) pdd_panel_disconnect_detector_i (
    .clk_sys_i(clk_sys), .resetn_i(resetn), .operator_panel_present_i(present),
    .alt_panel_model_i(alt_model), .reset_and_panel_loss_select_i(sel),
    .protective_trip_i(trip), .ext_reset_i(ext_rst), .drive_reset_o(drive_reset), .alarm_o(alarm));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [9:0] exp_alarm(input logic [7:0] code);
    return (code == pdd_pkg::CODE_NONE) ? 10'h000 : {2'b11, code};
  endfunction : exp_alarm

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic chk_alarm(input logic [7:0] code);
    chk(alarm, exp_alarm(code), "alarm");
  endtask : chk_alarm

  // one request cycle; pulse must follow by exactly one edge
  task automatic req(input logic ok);
    @(negedge clk_sys);
    ext_rst = 1'b1;
    cyc(1);
    chk({9'h000, drive_reset}, {9'h000, ok}, "reset pulse");
    ext_rst = 1'b0;
    cyc(1);
    chk({9'h000, drive_reset}, 10'h000, "reset end");
  endtask : req

  task automatic hw_reset();
    resetn = 1'b0;
    cyc(10);
    resetn = 1'b1;
  endtask : hw_reset

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_sel0();
    sel = 2'h0;
    pdd_panel_model_i.attach();
    cyc(2);
    pdd_panel_model_i.detach();
    cyc(L + 10);
    chk_alarm(pdd_pkg::CODE_NONE);
    req(1'b1);
  endtask : t_sel0

  task automatic t_sel1();
    sel = 2'h1;
    pdd_panel_model_i.attach();
    cyc(2);
    req(1'b0);
    trip = 1'b1;
    req(1'b1);
    trip = 1'b0;
    pdd_panel_model_i.detach();
    cyc(L + 10);
    chk_alarm(pdd_pkg::CODE_NONE);
  endtask : t_sel1

  task automatic t_sel2();
    sel = 2'h2;
    pdd_panel_model_i.attach();
    cyc(2);
    pdd_panel_model_i.detach();
    cyc(L);
    pdd_panel_model_i.attach();
    cyc(L + 4);
    chk_alarm(pdd_pkg::CODE_NONE);
    pdd_panel_model_i.detach();
    cyc(L + 1);
    chk_alarm(pdd_pkg::CODE_NONE);
    cyc(1);
    chk_alarm(pdd_pkg::PANEL_LOSS_FAULT_CODE);
    pdd_panel_model_i.attach();
    cyc(20);
    chk_alarm(pdd_pkg::PANEL_LOSS_FAULT_CODE);
    req(1'b1);
    chk_alarm(pdd_pkg::CODE_NONE);
  endtask : t_sel2

  task automatic t_sel3();
    sel = 2'h3;
    pdd_panel_model_i.attach();
    cyc(2);
    req(1'b0);
    pdd_panel_model_i.set_alt(1'b1);
    pdd_panel_model_i.detach();
    cyc(L + 2);
    chk_alarm(pdd_pkg::ALT_PANEL_LOSS_FAULT_CODE);
    req(1'b1);
    chk_alarm(pdd_pkg::CODE_NONE);
    cyc(L + 10);
    chk_alarm(pdd_pkg::CODE_NONE);
    pdd_panel_model_i.set_alt(1'b0);
  endtask : t_sel3

  // panel missing from power-up never trips
  task automatic t_never_seen();
    sel = 2'h2;
    // arm first, so the restart really has to forget a seen panel
    pdd_panel_model_i.attach();
    cyc(2);
    resetn = 1'b0;
    pdd_panel_model_i.detach();
    hw_reset();
    chk_alarm(pdd_pkg::CODE_NONE);
    chk({9'h000, drive_reset}, 10'h000, "reset out after restart");
    cyc(L + 10);
    chk_alarm(pdd_pkg::CODE_NONE);
  endtask : t_never_seen

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // whole sequence needs well under a thousand cycles
  initial
  begin
    #20000;
    num_errors++;
    summarize();
  end

  initial
  begin
    hw_reset();
    chk(alarm, 10'h000, "alarm after reset");
    chk({9'h000, drive_reset}, 10'h000, "reset out after reset");
    t_sel0();
    t_sel1();
    t_sel2();
    t_sel3();
    t_never_seen();
    summarize();
  end
endmodule : pdd_panel_disconnect_detector_test

//--- verif/pdd_panel_model.sv
// operator panel model: presence pin and model-select pin
// assumes the bench calls its tasks; pins change at the falling edge
`timescale 1ns/100ps
module pdd_panel_model (
  // clock
  input wire logic clk_sys_i,
  // panel pins
  output logic present_o,
  output logic alt_model_o
);
  // absent at start, so a power-up without panel is exercised
  initial
  begin
    present_o = 1'b0;
    alt_model_o = 1'b0;
  end

  // operator plugs the panel in firmly
  task automatic attach();
    @(negedge clk_sys_i);
    present_o = 1'b1;
  endtask : attach

  task automatic detach();
    @(negedge clk_sys_i);
    present_o = 1'b0;
  endtask : detach

  task automatic set_alt(input logic alt);
    @(negedge clk_sys_i);
    alt_model_o = alt;
  endtask : set_alt
endmodule : pdd_panel_model
